//--- core/tco_pkg.sv
package tco_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_COUNT  = 8'h04;
    localparam logic [7:0] OFS_CMP_A  = 8'h08;
    localparam logic [7:0] OFS_CMP_B  = 8'h0c;
    localparam logic [7:0] OFS_FLAGS  = 8'h10;
    localparam logic [7:0] OFS_FORCE  = 8'h14;
    localparam logic [7:0] OFS_PORT   = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FLAG_OVF_BIT   = 0;
    localparam int FLAG_CMP_LSB   = 1;
    localparam int STAT_LATCH_LSB = 0;
    localparam int STAT_CNT_LSB   = 8;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [9:0] CTRL_RST  = 10'h000;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    localparam logic [3:0] PORT_RST  = 4'h0;
    localparam logic       LATCH_RST = 1'b0;

    // ------------------------------------------------------------
    // Modes and encodings
    // ------------------------------------------------------------
    localparam logic [2:0] WGM_NORMAL   = 3'h0;
    localparam logic [2:0] WGM_CTC      = 3'h2;
    localparam logic [2:0] WGM_FAST_CMP = 3'h7;
    localparam logic [1:0] COM_OFF      = 2'h0;
    localparam logic [1:0] COM_TOGGLE   = 2'h1;
    localparam logic [1:0] COM_CLEAR    = 2'h2;
    localparam logic [1:0] COM_SET      = 2'h3;
    localparam logic [7:0] CNT_MAX      = 8'hff;
    localparam logic [7:0] CNT_BOTTOM   = 8'h00;

    // ------------------------------------------------------------
    // Prescaler: clock select codes and divider masks
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIV1   = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;
    localparam logic [9:0] MASK_8    = 10'h007;
    localparam logic [9:0] MASK_64   = 10'h03f;
    localparam logic [9:0] MASK_256  = 10'h0ff;
    localparam logic [9:0] MASK_1K   = 10'h3ff;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cs;
        logic [2:0] wgm;
        logic [1:0] com_b;
        logic [1:0] com_a;
    } tco_ctrl_t;

    typedef struct packed {
        logic [1:0] dir;
        logic [1:0] out;
    } tco_port_t;

endpackage

//--- core/tco_timer8.sv
`timescale 1ns/10ps

module tco_timer8
    import tco_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [1:0]             pin_out,
    output logic [1:0]             pin_oe
);

    // ------------------------------------------------------------
    // Byte-lane merge
    // ------------------------------------------------------------
    function automatic logic [31:0] tco_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              do_wr;
    logic [7:0]        wr_ofs;
    logic [7:0]        rd_ofs;
    logic [31:0]       rd_word;
    logic              rd_hit;
    logic              wr_hit;

    assign do_wr  = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_ofs = 8'(awaddr_reg & ~ADDR_W'(3));
    assign rd_ofs = 8'(s_axi_araddr & ~ADDR_W'(3));
    assign wr_hit = (wr_ofs[7:5] == 3'h0);
    assign rd_hit = (rd_ofs[7:5] == 3'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_reg   <= 1'b0;
            awaddr_reg    <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_wr) begin
            aw_full_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_full_reg   <= 1'b0;
            wdata_reg    <= '0;
            wstrb_reg    <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_wr) begin
            w_full_reg   <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    tco_ctrl_t   ctrl_reg;
    tco_port_t   port_reg;
    logic [7:0]  cmp_reg [2];
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic        ovf_reg;
    logic [1:0]  flag_reg;
    logic [1:0]  latch_reg;
    logic [1:0]  com [2];
    logic        cnt_wr;
    logic        flag_wr;
    logic [1:0]  force_wr;
    logic [31:0] wr_merged;

    assign com[0]    = ctrl_reg.com_a;
    assign com[1]    = ctrl_reg.com_b;
    assign wr_merged = tco_merge(32'h0000_0000, wdata_reg, wstrb_reg);
    assign cnt_wr    = do_wr && (wr_ofs == OFS_COUNT) && wstrb_reg[0];
    assign flag_wr   = do_wr && (wr_ofs == OFS_FLAGS);
    assign force_wr  = (do_wr && (wr_ofs == OFS_FORCE)) ? wr_merged[1:0] : 2'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= tco_ctrl_t'(CTRL_RST);
            port_reg   <= tco_port_t'(PORT_RST);
            cmp_reg[0] <= CMP_RST;
            cmp_reg[1] <= CMP_RST;
        end else if (do_wr) begin
            case (wr_ofs)
                OFS_CTRL: begin
                    ctrl_reg <= tco_ctrl_t'(10'(tco_merge(32'(ctrl_reg), wdata_reg, wstrb_reg)));
                end
                // Compare values are unbuffered: a value below the count waits for the wrap
                OFS_CMP_A: begin
                    cmp_reg[0] <= wstrb_reg[0] ? wdata_reg[7:0] : cmp_reg[0];
                end
                OFS_CMP_B: begin
                    cmp_reg[1] <= wstrb_reg[0] ? wdata_reg[7:0] : cmp_reg[1];
                end
                OFS_PORT: begin
                    port_reg <= wstrb_reg[0] ? tco_port_t'(wdata_reg[3:0]) : port_reg;
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_ofs)
            OFS_CTRL:   rd_word = 32'(ctrl_reg);
            OFS_COUNT:  rd_word = 32'(cnt_reg);
            OFS_CMP_A:  rd_word = 32'(cmp_reg[0]);
            OFS_CMP_B:  rd_word = 32'(cmp_reg[1]);
            OFS_FLAGS:  rd_word = 32'({flag_reg, ovf_reg});
            OFS_PORT:   rd_word = 32'(port_reg);
            OFS_STATUS: rd_word = 32'({cnt_reg, 6'h00, latch_reg});
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [9:0] presc_reg;
    logic       tick;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 10'h000;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    // Codes 6 and 7 (external source) have no pin here, so they stop the timer
    always_comb begin
        case (ctrl_reg.cs)
            CS_DIV1:   tick = 1'b1;
            CS_DIV8:   tick = ((presc_reg & MASK_8) == MASK_8);
            CS_DIV64:  tick = ((presc_reg & MASK_64) == MASK_64);
            CS_DIV256: tick = ((presc_reg & MASK_256) == MASK_256);
            CS_DIV1K:  tick = (presc_reg == MASK_1K);
            default:   tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter unit
    // ------------------------------------------------------------
    logic       block_reg;
    logic [1:0] match;
    logic       pwm;
    logic       top_clear;
    logic       wrap_ev;
    logic       ovf_set;

    assign pwm = ctrl_reg.wgm[0];
    // Blocking lasts one timer cycle, so a stopped timer keeps it until the first tick
    assign match[0] = tick && !cnt_wr && !block_reg && (cnt_reg == cmp_reg[0]);
    assign match[1] = tick && !cnt_wr && !block_reg && (cnt_reg == cmp_reg[1]);
    // Sequence uses the waveform mode and compare A only, never compare B
    assign top_clear = ((ctrl_reg.wgm == WGM_CTC) && match[0])
                     || ((ctrl_reg.wgm == WGM_FAST_CMP) && (cnt_reg == cmp_reg[0]));
    assign wrap_ev  = tick && !cnt_wr && (top_clear || (cnt_reg == CNT_MAX));
    assign ovf_set  = tick && !cnt_wr && (cnt_reg == CNT_MAX);
    assign cnt_next = top_clear ? CNT_BOTTOM : cnt_reg + 8'h01;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= COUNT_RST;
        end else if (cnt_wr) begin
            cnt_reg <= wdata_reg[7:0];
        end else if (tick) begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            block_reg <= 1'b0;
        end else if (cnt_wr) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    // Set beats a write-one clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= 1'b0;
        end else if (ovf_set) begin
            ovf_reg <= 1'b1;
        end else if (flag_wr && wr_merged[FLAG_OVF_BIT]) begin
            ovf_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Compare output channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flag_reg[i] <= 1'b0;
            end else if (match[i]) begin
                flag_reg[i] <= 1'b1;
            end else if (flag_wr && wr_merged[FLAG_CMP_LSB + i]) begin
                flag_reg[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                latch_reg[i] <= LATCH_RST;
            end else if (!pwm && (match[i] || force_wr[i])) begin
                case (com[i])
                    COM_TOGGLE: latch_reg[i] <= ~latch_reg[i];
                    COM_CLEAR:  latch_reg[i] <= 1'b0;
                    COM_SET:    latch_reg[i] <= 1'b1;
                    default:    latch_reg[i] <= latch_reg[i];
                endcase
            end else if (pwm && wrap_ev) begin
                // Bottom wins so a compare at top gives a steady level
                case (com[i])
                    COM_CLEAR:  latch_reg[i] <= 1'b1;
                    COM_SET:    latch_reg[i] <= 1'b0;
                    default:    latch_reg[i] <= latch_reg[i];
                endcase
            end else if (pwm && match[i]) begin
                case (com[i])
                    COM_TOGGLE: latch_reg[i] <= (i == 0 && ctrl_reg.wgm[2]) ? ~latch_reg[i] : latch_reg[i];
                    COM_CLEAR:  latch_reg[i] <= 1'b0;
                    COM_SET:    latch_reg[i] <= 1'b1;
                    default:    latch_reg[i] <= latch_reg[i];
                endcase
            end
        end

        // Pin path is registered: one clock behind the latch and port bits
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pin_out[i] <= 1'b0;
                pin_oe[i]  <= 1'b0;
            end else begin
                pin_out[i] <= (com[i] != COM_OFF) ? latch_reg[i] : port_reg.out[i];
                pin_oe[i]  <= port_reg.dir[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    reset_latch_a: assert property (!$past(rst_n) |-> latch_reg == 2'h0)
        else $error("latch not cleared by reset");
    pin_select_a: assert property ((ctrl_reg.com_a != COM_OFF) |=> pin_out[0] == $past(latch_reg[0]))
        else $error("pin A not driven from latch");
    pin_dir_a: assert property (port_reg.dir[1] |=> pin_oe[1])
        else $error("pin B direction ignored");
    com_hold_a: assert property ((ctrl_reg.com_a == COM_OFF) |=> $stable(latch_reg[0]))
        else $error("latch A moved with compare mode off");
    normal_wrap_a: assert property ((tick && !cnt_wr && ctrl_reg.wgm == WGM_NORMAL && cnt_reg == CNT_MAX)
        |=> (cnt_reg == CNT_BOTTOM) && ovf_reg)
        else $error("normal mode wrap or overflow wrong");
    ctc_clear_a: assert property ((ctrl_reg.wgm == WGM_CTC && match[0])
        |=> cnt_reg == CNT_BOTTOM && flag_reg[0])
        else $error("match did not clear counter");
    ctc_toggle_a: assert property ((ctrl_reg.wgm == WGM_CTC && ctrl_reg.com_a == COM_TOGGLE && match[0])
        |=> latch_reg[0] != $past(latch_reg[0]))
        else $error("output A did not toggle");
    stop_hold_a: assert property ((ctrl_reg.cs == CS_STOP && !cnt_wr) |=> $stable(cnt_reg))
        else $error("stopped counter moved");
    write_block_a: assert property ((cnt_wr ##1 (!cnt_wr && tick && !flag_reg[0])) |=> !flag_reg[0])
        else $error("match not blocked after counter write");
    ovf_sticky_a: assert property ((ovf_reg && !flag_wr) |=> ovf_reg)
        else $error("overflow flag lost without clear");

    ctc_cycle_c:  cover property (ctrl_reg.wgm == WGM_CTC && match[0] ##1 cnt_reg == CNT_BOTTOM);
    force_c:      cover property (!pwm && force_wr[0] && ctrl_reg.com_a == COM_SET);
    wrap_ovf_c:   cover property (ovf_set ##1 ovf_reg);
    flag_clear_c: cover property (flag_reg[0] ##1 !flag_reg[0]);

endmodule

//--- test/tco_timer8_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((e) !== (a)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module tco_timer8_tb_top
    import tco_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, pin_out, pin_oe, rsp;
    logic [31:0] d;
    int          err_count = 0, samples_checked = 0, g;
    // ------------------------------------------------------------
    // Clock, device, watchdog
    // ------------------------------------------------------------
    always #10 clk = ~clk;
    tco_timer8 #(.ADDR_W(8)) tco_timer8_inst (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_out(pin_out), .pin_oe(pin_oe));
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        end_sim();
    end
    // ------------------------------------------------------------
    // Bus tasks; waits are bounded so a dead slave cannot hang us
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        r = 2'h1;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp; bready <= 1'b0; n = 200;
            end
        end
        if (n < 200) `CHK("write timeout", 1'b1, 1'b0)
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        v = '0;
        r = 2'h1;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (n < 100) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata; r = rresp; rready <= 1'b0; n = 200;
            end
        end
        if (n < 200) `CHK("read timeout", 1'b1, 1'b0)
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] cs, input logic [2:0] wgm, input logic [1:0] com);
        return {22'h0, cs, wgm, 2'h0, com};
    endfunction
    // Cycles between two pin A changes, skipping the first irregular one
    task automatic gap(output int c);
        logic p;
        c = 0;
        @(posedge clk);
        p = pin_out[0];
        while (pin_out[0] === p && c < 300) begin @(posedge clk); c++; end
        p = pin_out[0];
        c = 0;
        do begin @(posedge clk); c++; end while (pin_out[0] === p && c < 300);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        `CHK("pins after reset", 4'h0, {pin_out, pin_oe})
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), d, rsp);
            `CHK("reset word", 32'h0, d)
        end
        rd(8'h20, d, rsp);
        `CHK("unmapped read", RESP_SLVERR, rsp)
        wr(8'h24, 32'h1, rsp);
        `CHK("unmapped write", RESP_SLVERR, rsp)
        // Latch actions by force strobe; port A out 1, dir A out
        wr(OFS_PORT, 32'h5, rsp);
        for (int i = 0; i < 5; i++) begin
            logic [1:0] com;
            logic       exp;
            com = (i == 0) ? COM_SET : (i == 1) ? COM_CLEAR : (i < 4) ? COM_TOGGLE : COM_OFF;
            exp = (i == 0 || i == 2);
            wr(OFS_CTRL, ctl(CS_STOP, i[0] ? WGM_CTC : WGM_NORMAL, com), rsp);
            wr(OFS_FORCE, 32'h1, rsp);
            repeat (2) @(posedge clk);
            rd(OFS_STATUS, d, rsp);
            `CHK("latch", exp, d[0])
            `CHK("pin source", (com != COM_OFF) ? exp : 1'b1, pin_out[0])
            `CHK("pin enable", 1'b1, pin_oe[0])
        end
        wr(OFS_PORT, 32'ha, rsp);
        repeat (2) @(posedge clk);
        `CHK("dir input", 1'b0, pin_oe[0])
        `CHK("pin B", 2'h3, {pin_out[1], pin_oe[1]})
        // Stopped counter still writable
        wr(OFS_COUNT, 32'h10, rsp);
        repeat (10) @(posedge clk);
        rd(OFS_COUNT, d, rsp);
        `CHK("held count", 32'h10, d)
        // Free run across the wrap
        wr(OFS_COUNT, 32'hf0, rsp);
        wr(OFS_CTRL, ctl(CS_DIV1, WGM_NORMAL, COM_OFF), rsp);
        repeat (30) @(posedge clk);
        wr(OFS_CTRL, ctl(CS_STOP, WGM_NORMAL, COM_OFF), rsp);
        rd(OFS_COUNT, d, rsp);
        `CHK("wrapped", 1'b1, d[7:0] < 8'h40)
        rd(OFS_FLAGS, d, rsp);
        `CHK("overflow set", 1'b1, d[0])
        repeat (5) @(posedge clk);
        rd(OFS_FLAGS, d, rsp);
        `CHK("overflow sticky", 1'b1, d[0])
        wr(OFS_FLAGS, 32'h7, rsp);
        rd(OFS_FLAGS, d, rsp);
        `CHK("flags cleared", 32'h0, d)
        // Clear on match with toggle output at three prescales
        wr(OFS_CMP_A, 32'h3, rsp);
        wr(OFS_PORT, 32'h4, rsp);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_COUNT, 32'h0, rsp);
            wr(OFS_CTRL, ctl((i == 2) ? CS_DIV64 : i ? CS_DIV8 : CS_DIV1, WGM_CTC, COM_TOGGLE), rsp);
            gap(g);
            `CHK("half period", (i == 2) ? 256 : i ? 32 : 4, g)
            wr(OFS_CTRL, ctl(CS_STOP, WGM_CTC, COM_TOGGLE), rsp);
            rd(OFS_COUNT, d, rsp);
            `CHK("count below top", 1'b1, d[7:0] <= 8'h03)
            rd(OFS_FLAGS, d, rsp);
            `CHK("compare flag", 1'b1, d[1])
        end
        // Top below the count: must run past, not clear
        wr(OFS_COUNT, 32'h10, rsp);
        wr(OFS_CMP_A, 32'h5, rsp);
        wr(OFS_CTRL, ctl(CS_DIV1, WGM_CTC, COM_OFF), rsp);
        repeat (20) @(posedge clk);
        wr(OFS_CTRL, ctl(CS_STOP, WGM_CTC, COM_OFF), rsp);
        rd(OFS_COUNT, d, rsp);
        `CHK("runs past top", 1'b1, d[7:0] > 8'h10)
        // Count write equal to top: first match blocked
        wr(OFS_FLAGS, 32'h7, rsp);
        wr(OFS_COUNT, 32'h5, rsp);
        wr(OFS_CTRL, ctl(CS_DIV1, WGM_CTC, COM_OFF), rsp);
        repeat (5) @(posedge clk);
        wr(OFS_CTRL, ctl(CS_STOP, WGM_CTC, COM_OFF), rsp);
        rd(OFS_FLAGS, d, rsp);
        `CHK("blocked match", 1'b0, d[1])
        rd(OFS_COUNT, d, rsp);
        `CHK("no clear", 1'b1, d[7:0] > 8'h05)
        // Same while running: at divide-by-1 the write lands on a tick cycle
        wr(OFS_FLAGS, 32'h7, rsp);
        wr(OFS_CTRL, ctl(CS_DIV1, WGM_CTC, COM_OFF), rsp);
        wr(OFS_COUNT, 32'h5, rsp);
        repeat (5) @(posedge clk);
        wr(OFS_CTRL, ctl(CS_STOP, WGM_CTC, COM_OFF), rsp);
        rd(OFS_FLAGS, d, rsp);
        `CHK("blocked running", 1'b0, d[1])
        // Top at max: the clear is also the overflow
        wr(OFS_FLAGS, 32'h7, rsp);
        wr(OFS_CMP_A, 32'hff, rsp);
        wr(OFS_COUNT, 32'hf8, rsp);
        wr(OFS_CTRL, ctl(CS_DIV1, WGM_CTC, COM_OFF), rsp);
        repeat (10) @(posedge clk);
        wr(OFS_CTRL, ctl(CS_STOP, WGM_CTC, COM_OFF), rsp);
        rd(OFS_FLAGS, d, rsp);
        `CHK("ctc overflow", 2'h3, d[1:0])
        // Fast PWM, top at max: bottom sets non-inverted, clears inverted
        for (int i = 0; i < 2; i++) begin
            wr(OFS_COUNT, 32'hfc, rsp);
            wr(OFS_CTRL, ctl(CS_DIV1, 3'h3, i ? COM_SET : COM_CLEAR), rsp);
            repeat (10) @(posedge clk);
            wr(OFS_CTRL, ctl(CS_STOP, 3'h3, i ? COM_SET : COM_CLEAR), rsp);
            rd(OFS_STATUS, d, rsp);
            `CHK("pwm polarity", i ? 1'b0 : 1'b1, d[0])
        end
        end_sim();
    end
endmodule
